// >>> sim/lsm_host_model.sv
`timescale 1ns/1ns
// ==========================================================
// Host side: sends command lines, collects reply bytes
module lsm_host_model (
   // Clock
   input wire logic clk_i,
   // Command bytes toward the block
   output logic [7:0] rx_data_o,
   output logic rx_valid_o,
   input wire logic rx_ready_i,
   // Reply bytes from the block
   input wire logic [7:0] tx_data_i,
   input wire logic tx_valid_i,
   output logic tx_ready_o,
   // Stall control
   input wire logic slow_i
);
   logic [7:0] got_q[$];
   logic tog_ff = 1'h0;
   int lost = 0;
   initial begin
      rx_data_o = 8'h00;
      rx_valid_o = 1'h0;
   end
   // Reply acceptance, every other cycle when stalling
   assign tx_ready_o = slow_i ? tog_ff : 1'h1;
   // Collect accepted reply bytes
   always @(posedge clk_i) begin
      tog_ff <= ~tog_ff;
      if (tx_valid_i && tx_ready_o) begin
         got_q.push_back(tx_data_i);
      end
   end
   // One byte, held until the edge that accepts it
   task send_byte(input logic [7:0] b);
      int n;
      @(posedge clk_i);
      rx_data_o <= b;
      rx_valid_o <= 1'h1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (rx_ready_i !== 1'h1 && n < 1000);
      if (rx_ready_i !== 1'h1) begin
         lost++;
      end
      rx_valid_o <= 1'h0;
      rx_data_o <= ~b; // Released data no longer meaningful
   endtask
   // Text line with the delimiter pair appended
   task send_line(input string s);
      foreach (s[i]) begin
         send_byte(s[i]);
      end
      send_byte(lsm_pkg::CH_CR);
      send_byte(lsm_pkg::CH_LF);
   endtask
endmodule // lsm_host_model

// >>> sim/lsm_top_assertions.sv
`timescale 1ns/1ns
// ==========================================================
// Port checks on the command block
module lsm_top_checker (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Register bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   // Byte streams
   input wire logic rx_ready_o,
   input wire logic [7:0] tx_data_o,
   input wire logic tx_valid_o,
   input wire logic tx_ready_i,
   // Control outputs
   input wire logic bank_sel_o,
   input wire logic active_bank_o,
   input wire logic soft_restart_o,
   input wire logic defaults_clear_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Bus answers exactly one cycle after the request
   property p_ack_answer;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_answer: assert property (p_ack_answer) else $error("ack late");
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
   // Stalled reply byte stays put
   property p_tx_hold;
      tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o);
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("tx byte lost");
   property p_tx_ascii;
      tx_valid_o |-> !tx_data_o[7];
   endproperty
   a_tx_ascii: assert property (p_tx_ascii) else $error("tx non-text");
   // Carriage return is followed by line feed
   property p_crlf;
      tx_valid_o && tx_ready_i && tx_data_o == lsm_pkg::CH_CR
         |=> tx_valid_o && tx_data_o == lsm_pkg::CH_LF;
   endproperty
   a_crlf: assert property (p_crlf) else $error("no line feed");
   property p_rx_busy;
      tx_valid_o |-> !rx_ready_o;
   endproperty
   a_rx_busy: assert property (p_rx_busy) else $error("rx open");
   // Restart pulses and bank switch
   property p_restart_pulse;
      soft_restart_o |=> !soft_restart_o;
   endproperty
   a_restart_pulse: assert property (p_restart_pulse) else $error("rst");
   property p_clear_with_restart;
      defaults_clear_o |-> soft_restart_o;
   endproperty
   a_clear_with_restart: assert property (p_clear_with_restart)
      else $error("clear without restart");
   property p_bank_switch;
      soft_restart_o |-> active_bank_o == bank_sel_o;
   endproperty
   a_bank_switch: assert property (p_bank_switch) else $error("bank");
   // Main scenarios
   c_restart: cover property (soft_restart_o && defaults_clear_o);
   c_stall: cover property (tx_valid_o && !tx_ready_i);
   c_reply_end: cover property (tx_valid_o && tx_data_o == lsm_pkg::CH_LF);
endmodule // lsm_top_checker
bind lsm_top lsm_top_checker chk_u (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .rx_ready_o(rx_ready_o), .tx_data_o(tx_data_o),
   .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
   .bank_sel_o(bank_sel_o), .active_bank_o(active_bank_o),
   .soft_restart_o(soft_restart_o), .defaults_clear_o(defaults_clear_o));

// >>> sim/lsm_top_tb_top.sv
`timescale 1ns/1ns
// ==========================================================
// Self-checking bench for the command block
module lsm_top_tb_top;
   // Arbitrary identification texts
   localparam logic [95:0] VER_TXT = "REV 0.50 XYZ";
   localparam logic [31:0] HWR_TXT = "HW1A";
   logic clk_i = 1'h0, rst_i = 1'h1;
   logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, wb_ack_o;
   logic [7:0] wb_adr_i = 8'h00, rx_data_i, tx_data_o;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
   logic rx_valid_i, rx_ready_o, tx_valid_o, tx_ready_i;
   logic [3:0] cw = 4'h0, ccw = 4'h0, home = 4'h0, scw = 4'h0, sccw = 4'h0;
   logic [63:0] chip = 64'h0;
   logic [3:0] sel = 4'hf;
   logic stop = 1'h0, speed = 1'h0, mode = 1'h0, ldr = 1'h0, slow = 1'h0;
   logic bboot = 1'h0;
   logic led, bsel, abank, rstp, clr;
   int failures = 0, num_checks = 0, c;
   string s;
   always #25 clk_i = ~clk_i;
   lsm_top #(.MS_CYCLES(4), .RECV_MS(1200), .WRITE_MS(300), .LOADER_MS(5),
      .VERSION_TEXT(VER_TXT), .HW_REV_TEXT(HWR_TXT)) dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(sel),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o),
      .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
      .clockwise_limit_switch_i(cw), .counterclockwise_limit_switch_i(ccw),
      .home_limit_switch_i(home), .btn_stop_i(stop), .btn_speed_i(speed),
      .btn_mode_i(mode), .loader_select_switch_i(ldr), .soft_cw_limit_i(scw),
      .soft_ccw_limit_i(sccw), .chip_status_i(chip), .boot_bank_i(bboot),
      .remote_led_o(led), .bank_sel_o(bsel), .active_bank_o(abank),
      .soft_restart_o(rstp), .defaults_clear_o(clr));
   lsm_host_model host_u (.clk_i(clk_i), .rx_data_o(rx_data_i),
      .rx_valid_o(rx_valid_i), .rx_ready_i(rx_ready_o),
      .tx_data_i(tx_data_o), .tx_valid_i(tx_valid_o),
      .tx_ready_o(tx_ready_i), .slow_i(slow));
   // ==========================================================
   // Checking and closing
   task chk(input string what, input logic [31:0] seen, input logic [31:0] e);
      num_checks++;
      if (seen !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, e, seen);
      end
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ==========================================================
   // Bus, stream and timing helpers
   task wb_rw(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'h1 && n < 100);
      q = wb_dat_o;
      chk("ack", wb_ack_o, 32'h1);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
   endtask
   task expect_reply(input string r);
      int n;
      n = 0;
      while (host_u.got_q.size() < r.len() + 2 && n < 900) begin
         @(posedge clk_i);
         n++;
      end
      r = {r, "\r\n"};
      for (int i = 0; i < r.len(); i++) begin
         chk("reply", host_u.got_q.size() ? host_u.got_q.pop_front() : 8'hxx,
            r[i]);
      end
   endtask
   task wait_state(input logic [4:0] st);
      int n;
      n = 0;
      do begin
         wb_rw(1'h0, lsm_pkg::REG_STAT, 32'h0);
         n++;
      end while (q[8:4] !== st && n < 2000);
      chk("state", q[8:4], st);
   endtask
   task half_len;
      logic l;
      for (int k = 0; k < 2; k++) begin
         l = led;
         c = 0;
         while (led === l && c < 3000) begin
            @(posedge clk_i);
            c++;
         end
      end
   endtask
   task wait_restart;
      c = 0;
      while (rstp !== 1'h1 && c < 50) begin
         @(posedge clk_i);
         c++;
      end
      chk("restart", rstp, 32'h1);
      chk("clear", clr, 32'h1);
   endtask
   task do_reset;
      rst_i <= 1'h1;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'h0;
      repeat (10) @(posedge clk_i);
   endtask
   // ==========================================================
   // Test sequence
   initial begin
      do_reset();
      wb_rw(1'h0, lsm_pkg::REG_CHAN, 32'h0);
      chk("chan", q, {16'h0, lsm_pkg::CHAN_MAP_RST});
      wb_rw(1'h0, 8'h10, 32'h0);
      chk("unmapped", q, 32'h0);
      $display("test registers done");
      {cw, ccw, home, scw, sccw, slow} <= {20'h53824, 1'h1};
      chip <= 64'h0f1e_2d3c_4b5a_6978;
      repeat (4) @(posedge clk_i);
      host_u.send_line($sformatf("%s", lsm_pkg::PAT_LIMIT));
      expect_reply("012332140124");
      sel <= 4'h2;
      wb_rw(1'h1, lsm_pkg::REG_CHAN, 32'h0123);
      sel <= 4'hf;
      wb_rw(1'h0, lsm_pkg::REG_CHAN, 32'h0);
      chk("lane", q, 32'h0110);
      {cw, ccw, home, scw, sccw} <= 20'hac35b;
      wb_rw(1'h1, lsm_pkg::REG_CHAN, 32'h0123);
      host_u.send_line($sformatf("%s", lsm_pkg::PAT_LIMIT));
      expect_reply("321045237612");
      host_u.send_line($sformatf("%s", lsm_pkg::PAT_STAT));
      expect_reply("6978/4B5A/2D3C/0F1E");
      host_u.send_line($sformatf("%s", lsm_pkg::PAT_VER));
      expect_reply($sformatf("%s", VER_TXT));
      host_u.send_line($sformatf("%s", lsm_pkg::PAT_HWREV));
      expect_reply($sformatf("%s", HWR_TXT));
      $display("test queries done");
      host_u.send_byte(8'hc1);
      host_u.send_line("");
      s = $sformatf("%s", lsm_pkg::PAT_BANKQ);
      foreach (s[i]) host_u.send_byte(s[i]);
      host_u.send_byte(lsm_pkg::CH_CR);
      repeat (20) @(posedge clk_i);
      chk("early reply", host_u.got_q.size(), 32'h0);
      wb_rw(1'h0, lsm_pkg::REG_REJ, 32'h0);
      chk("rejects", q, 32'h1);
      host_u.send_byte(lsm_pkg::CH_LF);
      expect_reply($sformatf("%s", {lsm_pkg::TOKEN_BANK, 8'h30}));
      host_u.send_line($sformatf("%s", lsm_pkg::PAT_BANK1));
      repeat (4) @(posedge clk_i);
      chk("selected", bsel, 32'h1);
      chk("running", abank, 32'h0);
      host_u.send_line($sformatf("%s", lsm_pkg::PAT_SOFT_RESTART_COMMAND));
      wait_restart();
      chk("running", abank, 32'h1);
      host_u.send_line($sformatf("%s", lsm_pkg::PAT_BANKQ));
      expect_reply($sformatf("%s", {lsm_pkg::TOKEN_BANK, 8'h31}));
      host_u.send_line($sformatf("%s", lsm_pkg::PAT_BANK0));
      repeat (4) @(posedge clk_i);
      chk("deselected", bsel, 32'h0);
      $display("test bank done");
      wb_rw(1'h1, lsm_pkg::REG_CTRL, 32'h1);
      host_u.send_line(":0011");
      wait_state(5'h04);
      half_len();
      chk("slow blink", c, 32'h7d0);
      wait_state(5'h08);
      half_len();
      chk("fast blink", c, 32'h190);
      wait_state(5'h02);
      chk("led off", led, 32'h0);
      chk("old still runs", abank, 32'h1);
      host_u.send_line($sformatf("%s", lsm_pkg::PAT_SOFT_RESTART_COMMAND));
      wait_restart();
      chk("new runs", abank, 32'h0);
      $display("test download done");
      bboot <= 1'h1;
      do_reset();
      chk("stored bank", abank, 32'h1);
      {stop, speed} <= 2'h3;
      do_reset();
      chk("recovered", abank, 32'h0);
      {speed, mode, ldr} <= 3'h3;
      do_reset();
      wait_state(5'h10);
      chk("loader flash", led, 32'h0);
      repeat (40) @(posedge clk_i);
      chk("loader led", led, 32'h1);
      $display("test boot modes done");
      chk("lost bytes", host_u.lost, 32'h0);
      complete_run();
   end
   // Hang guard
   initial begin
      repeat (60000) @(posedge clk_i);
      failures++;
      complete_run();
   end
endmodule // lsm_top_tb_top

// >>> src/lsm_pkg.sv
package lsm_pkg;
   // ==========================================================
   // Clock and timing
   localparam int CLK_HZ = 20_000_000;
   localparam int MS_PER_S = 1000;
   localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
   localparam int RECV_S = 90;
   localparam int WRITE_S = 20;
   localparam int LOADER_S = 15;
   localparam int RECV_MS = RECV_S * MS_PER_S;
   localparam int WRITE_MS = WRITE_S * MS_PER_S;
   localparam int LOADER_MS = LOADER_S * MS_PER_S;
   localparam logic [9:0] SLOW_HALF_MS = 10'h1f4;
   localparam logic [9:0] FAST_HALF_MS = 10'h064;
   localparam logic [1:0] BOOT_WAIT = 2'h3;

   // ==========================================================
   // Register map
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_CHAN = 8'h04;
   localparam logic [7:0] REG_STAT = 8'h08;
   localparam logic [7:0] REG_REJ = 8'h0c;
   localparam logic [15:0] CHAN_MAP_RST = 16'h3210;
   localparam int CTRL_REMOTE_BIT = 0;

   // ==========================================================
   // Characters and command patterns
   localparam logic [7:0] CH_CR = 8'h0d;
   localparam logic [7:0] CH_LF = 8'h0a;
   localparam logic [7:0] CH_SLASH = 8'h2f;
   localparam logic [7:0] CH_COLON = 8'h3a;
   localparam logic [7:0] CH_ZERO = 8'h30;
   localparam logic [55:0] PAT_LIMIT = 56'h48445354_4c533f;
   localparam logic [31:0] PAT_VER = 32'h5645523f;
   localparam logic [39:0] PAT_HWREV = 40'h56455248_3f;
   localparam logic [39:0] PAT_BANK0 = 40'h46524f4d_30;
   localparam logic [39:0] PAT_BANK1 = 40'h46524f4d_31;
   localparam logic [39:0] PAT_BANKQ = 40'h46524f4d_3f;
   localparam logic [31:0] PAT_SOFT_RESTART_COMMAND = 32'h52455354;
   localparam logic [39:0] PAT_STAT = 40'h5354454d_3f;
   localparam logic [31:0] TOKEN_BANK = 32'h46524f4d;
   localparam logic [4:0] LINE_BYTES = 5'h10;

   // ==========================================================
   // Controller states
   typedef enum logic [4:0] {
      ST_BOOT = 5'h01,
      ST_RUN = 5'h02,
      ST_RECV = 5'h04,
      ST_WRITE = 5'h08,
      ST_LOADER = 5'h10
   } lsm_state_t;
endpackage

// >>> src/lsm_top.sv
`timescale 1ns/1ns
module lsm_top #(
   parameter int MS_CYCLES = lsm_pkg::MS_CYCLES,
   parameter int RECV_MS = lsm_pkg::RECV_MS,
   parameter int WRITE_MS = lsm_pkg::WRITE_MS,
   parameter int LOADER_MS = lsm_pkg::LOADER_MS,
   // Arbitrary identification texts
   parameter logic [95:0] VERSION_TEXT = 96'h302e3030_2030302d_30302d30,
   parameter logic [31:0] HW_REV_TEXT = 32'h302e3030
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Command byte stream
   input wire logic [7:0] rx_data_i,
   input wire logic rx_valid_i,
   output logic rx_ready_o,
   output logic [7:0] tx_data_o,
   output logic tx_valid_o,
   input wire logic tx_ready_i,
   // Switch and button pins
   input wire logic [3:0] clockwise_limit_switch_i,
   input wire logic [3:0] counterclockwise_limit_switch_i,
   input wire logic [3:0] home_limit_switch_i,
   input wire logic btn_stop_i,
   input wire logic btn_speed_i,
   input wire logic btn_mode_i,
   input wire logic loader_select_switch_i,
   // Same-clock inputs
   input wire logic [3:0] soft_cw_limit_i,
   input wire logic [3:0] soft_ccw_limit_i,
   input wire logic [63:0] chip_status_i,
   input wire logic boot_bank_i,
   // Control outputs
   output logic remote_led_o,
   output logic bank_sel_o,
   output logic active_bank_o,
   output logic soft_restart_o,
   output logic defaults_clear_o
);

   typedef struct packed {
      logic [15:0] sync1;
      logic [15:0] sync2;
      lsm_pkg::lsm_state_t state;
      logic [1:0] boot_cnt;
      logic [127:0] line;
      logic [4:0] len;
      logic bad;
      logic [7:0] first;
      logic [255:0] reply;
      logic [5:0] rcnt;
      logic txv;
      logic rdy;
      logic [14:0] ms_cnt;
      logic [16:0] phase;
      logic [9:0] blink;
      logic blink_ph;
      logic led;
      logic remote;
      logic [15:0] chan_map;
      logic [15:0] rej;
      logic ack;
      logic [31:0] dat;
      logic act_bank;
      logic sel_bank;
      logic fw_pend;
      logic restart;
      logic dclr;
   } lsm_regs_t;

   localparam logic [14:0] MS_LAST = 15'(MS_CYCLES - 1);
   localparam logic [16:0] RECV_LAST = 17'(RECV_MS - 1);
   localparam logic [16:0] WRITE_LAST = 17'(WRITE_MS - 1);
   localparam logic [16:0] LOADER_LAST = 17'(LOADER_MS - 1);

   lsm_regs_t s_ff;
   lsm_regs_t nxt_s;
   logic tick;
   logic done;
   logic [255:0] r;
   logic [5:0] n;
   logic [8:0] sh;
   logic [4:0] cl;
   logic [9:0] half;

   function automatic logic [7:0] hex_char(input logic [3:0] v);
      hex_char = (v < 4'ha) ? (8'h30 + {4'h0, v}) : (8'h37 + {4'h0, v});
   endfunction

   // ==========================================================
   // Next-state logic
   always_comb begin
      nxt_s = s_ff;
      r = '0;
      n = '0;
      sh = '0;
      cl = '0;
      done = 1'b0;
      tick = (s_ff.ms_cnt == MS_LAST);
      half = (s_ff.state == lsm_pkg::ST_RECV) ? lsm_pkg::SLOW_HALF_MS
                                              : lsm_pkg::FAST_HALF_MS;
      nxt_s.restart = 1'b0;
      nxt_s.dclr = 1'b0;
      nxt_s.ack = 1'b0;

      // Pin synchronisers
      nxt_s.sync1 = {loader_select_switch_i, btn_mode_i, btn_speed_i,
                     btn_stop_i, home_limit_switch_i,
                     counterclockwise_limit_switch_i,
                     clockwise_limit_switch_i};
      nxt_s.sync2 = s_ff.sync1;

      // Millisecond divider and blink phase
      nxt_s.ms_cnt = tick ? '0 : s_ff.ms_cnt + 15'h0001;
      if (tick) begin
         if (s_ff.blink >= half - 10'h001) begin
            nxt_s.blink = '0;
            nxt_s.blink_ph = ~s_ff.blink_ph;
         end else begin
            nxt_s.blink = s_ff.blink + 10'h001;
         end
         if (!(s_ff.state == lsm_pkg::ST_LOADER &&
               s_ff.phase == LOADER_LAST)) begin
            nxt_s.phase = s_ff.phase + 17'h00001;
         end
      end

      // Transmit shifter
      if (s_ff.txv && tx_ready_i) begin
         nxt_s.reply = {s_ff.reply[247:0], 8'h00};
         nxt_s.rcnt = s_ff.rcnt - 6'h01;
      end

      // Controller sequence
      case (s_ff.state)
         lsm_pkg::ST_BOOT: begin
            nxt_s.boot_cnt = s_ff.boot_cnt + 2'h1;
            if (s_ff.boot_cnt == lsm_pkg::BOOT_WAIT) begin
               nxt_s.phase = '0;
               if (s_ff.sync2[15] && s_ff.sync2[12] && s_ff.sync2[14]) begin
                  nxt_s.state = lsm_pkg::ST_LOADER;
               end else begin
                  nxt_s.state = lsm_pkg::ST_RUN;
                  // Stop and speed held: previous bank
                  nxt_s.act_bank = boot_bank_i ^
                     (s_ff.sync2[12] & s_ff.sync2[13]);
                  nxt_s.sel_bank = nxt_s.act_bank;
               end
            end
         end
         lsm_pkg::ST_RUN: begin
         end
         lsm_pkg::ST_RECV: begin
            if (tick && s_ff.phase == RECV_LAST) begin
               nxt_s.state = lsm_pkg::ST_WRITE;
               nxt_s.phase = '0;
            end
         end
         lsm_pkg::ST_WRITE: begin
            if (tick && s_ff.phase == WRITE_LAST) begin
               nxt_s.state = lsm_pkg::ST_RUN;
               // New image sits in the other bank until restart
               nxt_s.sel_bank = ~s_ff.act_bank;
               nxt_s.fw_pend = 1'b1;
            end
         end
         lsm_pkg::ST_LOADER: begin
         end
         default: begin
            nxt_s.state = lsm_pkg::ST_BOOT;
         end
      endcase

      // Line assembly; bytes outside run state are absorbed
      if (rx_valid_i && s_ff.rdy && s_ff.state == lsm_pkg::ST_RUN) begin
         if (rx_data_i == lsm_pkg::CH_LF && s_ff.len != 5'h00 &&
             s_ff.line[7:0] == lsm_pkg::CH_CR) begin
            done = 1'b1;
         end else begin
            if (s_ff.len == 5'h00) begin
               nxt_s.first = rx_data_i;
            end
            nxt_s.line = {s_ff.line[119:0], rx_data_i};
            if (s_ff.len == lsm_pkg::LINE_BYTES) begin
               nxt_s.bad = 1'b1;
            end else begin
               nxt_s.len = s_ff.len + 5'h01;
            end
            if (rx_data_i[7]) begin
               nxt_s.bad = 1'b1;
            end
         end
      end

      // Decode of a complete line
      if (done) begin
         nxt_s.len = '0;
         nxt_s.bad = 1'b0;
         cl = s_ff.len - 5'h01;
         if (s_ff.bad) begin
            if (s_ff.rej != 16'hffff) begin
               nxt_s.rej = s_ff.rej + 16'h0001;
            end
         end else if (s_ff.first == lsm_pkg::CH_COLON && s_ff.remote) begin
            nxt_s.state = lsm_pkg::ST_RECV;
            nxt_s.phase = '0;
         end else if (cl == 5'h07 &&
                      s_ff.line[63:8] == lsm_pkg::PAT_LIMIT) begin
            for (int i = 0; i < 4; i++) begin
               r[8*(13-i)+:8] = hex_char(s_ff.chan_map[4*i+:4]);
               r[8*(9-i)+:8] = hex_char({1'b0, s_ff.sync2[8+i],
                  s_ff.sync2[4+i], s_ff.sync2[i]});
               r[8*(5-i)+:8] = hex_char({1'b0, s_ff.sync2[8+i],
                  soft_ccw_limit_i[i], soft_cw_limit_i[i]});
            end
            n = 6'h0e;
         end else if (cl == 5'h04 &&
                      s_ff.line[39:8] == lsm_pkg::PAT_VER) begin
            r[111:16] = VERSION_TEXT;
            n = 6'h0e;
         end else if (cl == 5'h05 &&
                      s_ff.line[47:8] == lsm_pkg::PAT_HWREV) begin
            r[47:16] = HW_REV_TEXT;
            n = 6'h06;
         end else if (cl == 5'h05 &&
                      s_ff.line[47:8] == lsm_pkg::PAT_BANKQ) begin
            r[55:16] = {lsm_pkg::TOKEN_BANK,
                        lsm_pkg::CH_ZERO | {7'h00, s_ff.act_bank}};
            n = 6'h07;
         end else if (cl == 5'h05 &&
                      s_ff.line[47:8] == lsm_pkg::PAT_BANK0) begin
            nxt_s.sel_bank = 1'b0;
         end else if (cl == 5'h05 &&
                      s_ff.line[47:8] == lsm_pkg::PAT_BANK1) begin
            nxt_s.sel_bank = 1'b1;
         end else if (cl == 5'h04 &&
                      s_ff.line[39:8] == lsm_pkg::PAT_SOFT_RESTART_COMMAND) begin
            nxt_s.act_bank = s_ff.sel_bank;
            nxt_s.restart = 1'b1;
            nxt_s.dclr = s_ff.fw_pend |
                         (s_ff.sel_bank != s_ff.act_bank);
            nxt_s.fw_pend = 1'b0;
         end else if (cl == 5'h05 &&
                      s_ff.line[47:8] == lsm_pkg::PAT_STAT) begin
            for (int i = 0; i < 4; i++) begin
               for (int j = 0; j < 4; j++) begin
                  r[8*(20-5*i-j)+:8] =
                     hex_char(chip_status_i[16*i+12-4*j+:4]);
               end
               if (i < 3) begin
                  r[8*(16-5*i)+:8] = lsm_pkg::CH_SLASH;
               end
            end
            n = 6'h15;
         end
      end

      // Reply load, left aligned with CR LF appended
      if (n != 6'h00) begin
         r[15:0] = {lsm_pkg::CH_CR, lsm_pkg::CH_LF};
         sh = {(6'h20 - n), 3'b000};
         nxt_s.reply = r << sh;
         nxt_s.rcnt = n;
      end
      nxt_s.txv = (nxt_s.rcnt != 6'h00);
      nxt_s.rdy = (nxt_s.rcnt == 6'h00);

      // Remote indicator
      case (s_ff.state)
         lsm_pkg::ST_RECV: nxt_s.led = s_ff.blink_ph;
         lsm_pkg::ST_WRITE: nxt_s.led = s_ff.blink_ph;
         lsm_pkg::ST_LOADER: begin
            nxt_s.led = (s_ff.phase == LOADER_LAST) ? 1'b1
                                                    : s_ff.blink_ph;
         end
         lsm_pkg::ST_RUN: nxt_s.led = s_ff.remote & ~s_ff.fw_pend;
         default: nxt_s.led = 1'b0;
      endcase

      // Wishbone slave, one wait state
      if (wb_cyc_i && wb_stb_i && !s_ff.ack) begin
         nxt_s.ack = 1'b1;
         nxt_s.dat = '0;
         if (wb_adr_i == lsm_pkg::REG_CTRL) begin
            if (wb_we_i && wb_sel_i[0]) begin
               nxt_s.remote = wb_dat_i[lsm_pkg::CTRL_REMOTE_BIT];
            end
            nxt_s.dat[lsm_pkg::CTRL_REMOTE_BIT] = s_ff.remote;
         end else if (wb_adr_i == lsm_pkg::REG_CHAN) begin
            if (wb_we_i && wb_sel_i[0]) begin
               nxt_s.chan_map[7:0] = wb_dat_i[7:0];
            end
            if (wb_we_i && wb_sel_i[1]) begin
               nxt_s.chan_map[15:8] = wb_dat_i[15:8];
            end
            nxt_s.dat[15:0] = s_ff.chan_map;
         end else if (wb_adr_i == lsm_pkg::REG_STAT) begin
            nxt_s.dat[8:0] = {s_ff.state, s_ff.fw_pend, s_ff.led,
                              s_ff.sel_bank, s_ff.act_bank};
         end else if (wb_adr_i == lsm_pkg::REG_REJ) begin
            nxt_s.dat[15:0] = s_ff.rej;
            if (wb_we_i && wb_sel_i[0]) begin
               // A reject in the clearing cycle still counts
               nxt_s.rej = (done && s_ff.bad) ? 16'h0001 : 16'h0000;
            end
         end
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_ff <= '0;
         s_ff.state <= lsm_pkg::ST_BOOT;
         s_ff.chan_map <= lsm_pkg::CHAN_MAP_RST;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // Outputs straight from the state register
   assign wb_dat_o = s_ff.dat;
   assign wb_ack_o = s_ff.ack;
   assign rx_ready_o = s_ff.rdy;
   assign tx_data_o = s_ff.reply[255:248];
   assign tx_valid_o = s_ff.txv;
   assign remote_led_o = s_ff.led;
   assign bank_sel_o = s_ff.sel_bank;
   assign active_bank_o = s_ff.act_bank;
   assign soft_restart_o = s_ff.restart;
   assign defaults_clear_o = s_ff.dclr;

endmodule // lsm_top
